// ==== shared/cmc_map.svh ====
// constants: pulse times, widths, reset values and timing counts
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

`define CMC_WORD_BITS      25
`define CMC_ADDR_BITS      14

// pulse-time codes on the phase input; a word runs T24 down to T0, then Tp
`define CMC_PT_T24         5'h18
`define CMC_PT_T21         5'h15
`define CMC_PT_T18         5'h12
`define CMC_PT_T12         5'h0C
`define CMC_PT_T10         5'h0A
`define CMC_PT_T9          5'h09
`define CMC_PT_T8          5'h08
`define CMC_PT_T7          5'h07
`define CMC_PT_T2          5'h02
`define CMC_PT_TP          5'h19

// address line field positions (line 1 is bit 13, weight 2^13)
`define CMC_STACK_MSB      13
`define CMC_STACK_LSB      12
`define CMC_YT_LSB         9
`define CMC_YC_LSB         6
`define CMC_XT_LSB         3
`define CMC_XC_LSB         0

// reset values
`define CMC_ADDR_RESET     14'h0000
`define CMC_WORD_RESET     25'h0000000
`define CMC_COUNT_RESET    11'h000

// one full memory cycle, longest time, rounded down to clocks
`define CMC_CLK_PERIOD_NS  5
`define CMC_CYCLE_NS       6000
`define CMC_CYCLE_CLKS     (`CMC_CYCLE_NS / `CMC_CLK_PERIOD_NS)
`define CMC_COUNT_BITS     11

`endif

// ==== shared/cmc_pkg.sv ====
// types shared by the core memory cycle control and its decoder
package cmc_pkg;

  // gray along idle -> read -> write -> tail -> idle
  typedef enum logic [1:0] {
    CMC_IDLE  = 2'b00,
    CMC_READ  = 2'b01,
    CMC_WRITE = 2'b11,
    CMC_TAIL  = 2'b10
  } cmc_state_type;

  typedef struct packed {
    logic read_drive;   // read current regulator enable
    logic write_drive;  // write current regulator enable
    logic inhibit;      // inhibit (digit) timing
    logic read_dir;     // drive direction toward zero
    logic write_dir;    // drive direction toward one
  } cmc_timing_type;

  typedef struct packed {
    logic [3:0] stack_sel;  // one of four 4096-word stacks
    logic [7:0] y_true;     // y true octal digit, one-hot
    logic [7:0] y_comp;     // y complement octal digit, one-hot
    logic [7:0] x_true;     // x true octal digit, one-hot
    logic [7:0] x_comp;     // x complement octal digit, one-hot
  } cmc_coord_type;

endpackage : cmc_pkg

// ==== hw/cmc_coord_decode.sv ====
// decoder from gated address lines to stack select and coordinate digits
`timescale 1ns/10ps
`include "cmc_map.svh"

module cmc_coord_decode (
  input  wire logic                       clk,    // 200 MHz clock
  input  wire logic                       reset,  // sync, active high
  input  wire logic                       ce,     // clock enable
  input  wire logic [`CMC_ADDR_BITS-1:0]  lines,  // gated address lines
  output cmc_pkg::cmc_coord_type          coord   // decoded selects
);
  import cmc_pkg::*;

  cmc_coord_type next_coord;
  logic [7:0]    digit [4];

  function automatic logic [7:0] octal_onehot(input logic [2:0] code);
    octal_onehot = 8'h01 << code;
  endfunction : octal_onehot

  // [R11] four octal sub-fields decoded
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_digit
      assign digit[g] = octal_onehot(lines[g*3 +: 3]);
    end
  endgenerate

  always_comb begin
    next_coord.stack_sel =
      4'h1 << lines[`CMC_STACK_MSB:`CMC_STACK_LSB];
    next_coord.y_true = digit[`CMC_YT_LSB/3];
    next_coord.y_comp = digit[`CMC_YC_LSB/3];
    next_coord.x_true = digit[`CMC_XT_LSB/3];
    next_coord.x_comp = digit[`CMC_XC_LSB/3];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coord <= '0;
    end else if (ce) begin
      coord <= next_coord;
    end
  end

endmodule : cmc_coord_decode

// ==== hw/cmc_core_memory_cycle_control.sv ====
// core memory cycle control: address gating, read, regenerate and write
`timescale 1ns/10ps
`include "cmc_map.svh"

// Operation
// [R01] reading zeroes the word, so it is always written back at once
// [R02] a full read plus write cycle must finish within 6 microseconds
// [R03] all 25 sense bits load in parallel into the data register
// [R04] inverted data register bits drive the 25 inhibit drivers
// [R05] write drives every core to one; inhibit leaves the zeros
// [R06] read current runs in the direction that switches cores to zero
// [R07] write reverses drive current on the same selected lines
// [R08] address lines follow the address register when not time-shared
// [R09] time-share takes w interlace on w priority, else y interlace
// [R10] line one weighs 2^13 down to line fourteen at 2^0
// [R11] x and y each split into true and complement decoded digits
// [R12] address cleared at T10, loaded at T9, held through write
// [R13] T8 clears data register, sets flag; T7 read drive to Tp
// [R14] sense strobed into data register at T2, never during write
// [R15] inhibit from T21 to T8; write drive from T18 to T12
module cmc_core_memory_cycle_control (
  input  wire logic                       clk,            // 200 MHz clock
  input  wire logic                       reset,          // sync reset
  input  wire logic                       ce,             // clock enable
  input  wire logic                       pulse_adv,      // new pulse time
  input  wire logic [4:0]                 pulse_time,     // T24..T0, Tp
  input  wire logic                       mem_request,    // start a cycle
  input  wire logic [`CMC_ADDR_BITS-1:0]  new_address,    // next address
  input  wire logic                       time_share,     // time-share sel
  input  wire logic                       w_priority,     // w buffer wins
  input  wire logic [`CMC_ADDR_BITS-1:0]  w_interlace_address_bit, // w adr
  input  wire logic [`CMC_ADDR_BITS-1:0]  y_interlace_address_bit, // y adr
  input  wire logic                       write_request,  // store new word
  input  wire logic [`CMC_WORD_BITS-1:0]  write_word,     // word to store
  input  wire logic [`CMC_WORD_BITS-1:0]  sense_bit,      // discriminators
  input  wire logic                       overrun_clear,  // clear overrun
  output logic [`CMC_ADDR_BITS-1:0]       address_reg,    // address reg
  output logic [`CMC_ADDR_BITS-1:0]       gated_address_line, // lines
  output cmc_pkg::cmc_coord_type          coord,          // decoded select
  output logic [`CMC_WORD_BITS-1:0]       mdr,            // data register
  output logic [`CMC_WORD_BITS-1:0]       inhibit_drive,  // inhibit drivers
  output cmc_pkg::cmc_timing_type         timing,         // drive timing
  output logic                            sense_strobe,   // strobe pulse
  output logic                            cycle_active_flag, // cycle on
  output logic                            cycle_overrun   // cycle too long
);
  import cmc_pkg::*;

  localparam logic [`CMC_COUNT_BITS-1:0] CYCLE_LIMIT =
    `CMC_COUNT_BITS'(`CMC_CYCLE_CLKS);

  cmc_state_type                state;
  cmc_state_type                next_state;
  logic                         pending;
  logic                         next_pending;
  logic [`CMC_ADDR_BITS-1:0]    next_address_reg;
  logic [`CMC_ADDR_BITS-1:0]    next_gated;
  logic [`CMC_WORD_BITS-1:0]    next_mdr;
  logic [`CMC_WORD_BITS-1:0]    next_inhibit_drive;
  cmc_timing_type               next_timing;
  logic                         next_strobe;
  logic                         next_flag;
  logic [`CMC_COUNT_BITS-1:0]   cycle_count;
  logic [`CMC_COUNT_BITS-1:0]   next_cycle_count;
  logic                         next_overrun;

  function automatic logic at_pt(input logic [4:0] code,
                                 input logic [4:0] pt);
    at_pt = (code == pt);
  endfunction : at_pt

  // address line gating
  always_comb begin
    // [R08] register feeds lines outside time-share
    next_gated = address_reg;
    if (time_share) begin
      // [R09] interlace source by priority
      if (w_priority) begin
        next_gated = w_interlace_address_bit;
      end else begin
        next_gated = y_interlace_address_bit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gated_address_line <= `CMC_ADDR_RESET;
    end else if (ce) begin
      gated_address_line <= next_gated;
    end
  end

  // [R10] bit 13 is line one, weight 2^13
  cmc_coord_decode u_decode (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .lines (gated_address_line),
    .coord (coord)
  );

  // cycle sequencer, stepped only on pulse-time boundaries
  always_comb begin
    next_state       = state;
    next_pending     = pending;
    next_address_reg = address_reg;
    next_mdr         = mdr;
    next_timing      = timing;
    next_flag        = cycle_active_flag;
    next_strobe      = 1'b0;

    if (pulse_adv) begin
      // [R12] clear address at T10, only once write drive is over
      if (at_pt(pulse_time, `CMC_PT_T10) && mem_request &&
          (state == CMC_IDLE || state == CMC_TAIL)) begin
        next_address_reg = `CMC_ADDR_RESET;
        next_pending     = 1'b1;
      end

      // [R12] load address at T9
      if (at_pt(pulse_time, `CMC_PT_T9) && pending) begin
        next_address_reg = new_address;
      end

      if (at_pt(pulse_time, `CMC_PT_T8)) begin
        // [R15] inhibit ends at T8
        next_timing.inhibit = 1'b0;
        if (state == CMC_TAIL) begin
          next_state = CMC_IDLE;
          next_flag  = 1'b0;
        end
        // [R13] clear data register, raise the flag
        if (pending) begin
          next_mdr     = `CMC_WORD_RESET;
          next_flag    = 1'b1;
          next_state   = CMC_READ;
          next_pending = 1'b0;
        end
      end

      // [R13] read drive on from T7
      if (at_pt(pulse_time, `CMC_PT_T7) && state == CMC_READ) begin
        next_timing.read_drive = 1'b1;
      end

      // [R14] strobe only in the read phase
      if (at_pt(pulse_time, `CMC_PT_T2) && state == CMC_READ) begin
        next_strobe = 1'b1;
        // [R03] parallel capture of all bits
        next_mdr    = sense_bit;
      end

      // [R01] read always flows straight into write-back
      if (at_pt(pulse_time, `CMC_PT_TP) && state == CMC_READ) begin
        next_timing.read_drive = 1'b0;
        next_state             = CMC_WRITE;
      end

      // new data replaces the regenerated word before inhibit starts
      if (at_pt(pulse_time, `CMC_PT_T24) && state == CMC_WRITE &&
          write_request) begin
        next_mdr = write_word;
      end

      // [R15] inhibit on from T21
      if (at_pt(pulse_time, `CMC_PT_T21) && state == CMC_WRITE) begin
        next_timing.inhibit = 1'b1;
      end

      // [R15] write drive from T18 to T12
      if (at_pt(pulse_time, `CMC_PT_T18) && state == CMC_WRITE) begin
        next_timing.write_drive = 1'b1;
      end
      if (at_pt(pulse_time, `CMC_PT_T12) && state == CMC_WRITE) begin
        next_timing.write_drive = 1'b0;
        next_state              = CMC_TAIL;
      end
    end

    // [R06] read direction while flag is up in the read phase
    next_timing.read_dir  = next_flag && (next_state == CMC_READ);
    // [R07] reversed direction for the write phase
    next_timing.write_dir = next_flag && (next_state == CMC_WRITE);
  end

  // [R04] complement side gated by inhibit timing
  // [R05] only zero bits are inhibited, so ones are written
  always_comb begin
    if (next_timing.inhibit) begin
      next_inhibit_drive = ~next_mdr;
    end else begin
      next_inhibit_drive = `CMC_WORD_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state             <= CMC_IDLE;
      pending           <= 1'b0;
      address_reg       <= `CMC_ADDR_RESET;
      mdr               <= `CMC_WORD_RESET;
      inhibit_drive     <= `CMC_WORD_RESET;
      timing            <= '0;
      sense_strobe      <= 1'b0;
      cycle_active_flag <= 1'b0;
    end else if (ce) begin
      state             <= next_state;
      pending           <= next_pending;
      address_reg       <= next_address_reg;
      mdr               <= next_mdr;
      inhibit_drive     <= next_inhibit_drive;
      timing            <= next_timing;
      sense_strobe      <= next_strobe;
      cycle_active_flag <= next_flag;
    end
  end

  // cycle length watch: read start to end of write drive
  always_comb begin
    next_cycle_count = cycle_count;
    next_overrun     = cycle_overrun;
    if (state == CMC_IDLE || state == CMC_TAIL) begin
      next_cycle_count = `CMC_COUNT_RESET;
    end else if (cycle_count != CYCLE_LIMIT) begin
      next_cycle_count = cycle_count + `CMC_COUNT_BITS'(1);
    end
    if (overrun_clear) begin
      next_overrun = 1'b0;
    end
    // [R02] set wins over a clear in the same cycle
    if ((state == CMC_READ || state == CMC_WRITE) &&
        cycle_count == CYCLE_LIMIT) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cycle_count   <= `CMC_COUNT_RESET;
      cycle_overrun <= 1'b0;
    end else if (ce) begin
      cycle_count   <= next_cycle_count;
      cycle_overrun <= next_overrun;
    end
  end

endmodule : cmc_core_memory_cycle_control

// ==== verification/cmc_cycle_asserts.sv ====
// checker on the core memory cycle control ports
`timescale 1ns/10ps
`include "cmc_map.svh"

module cmc_cycle_asserts (
  input wire logic                      clk,               // clock
  input wire logic                      reset,             // sync reset
  input wire logic                      ce,                // clock enable
  input wire logic                      pulse_adv,         // new pulse
  input wire logic [4:0]                pulse_time,        // pulse code
  input wire logic [`CMC_WORD_BITS-1:0] sense_bit,         // sense in
  input wire logic [`CMC_ADDR_BITS-1:0] address_reg,       // address
  input wire logic [`CMC_ADDR_BITS-1:0] gated_address_line, // lines
  input wire cmc_pkg::cmc_coord_type    coord,             // selects
  input wire logic [`CMC_WORD_BITS-1:0] mdr,               // data reg
  input wire logic [`CMC_WORD_BITS-1:0] inhibit_drive,     // inhibit
  input wire cmc_pkg::cmc_timing_type   timing,            // timing
  input wire logic                      sense_strobe,      // strobe
  input wire logic                      cycle_active_flag  // cycle on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_t2_pulse;
    ce && pulse_adv && pulse_time == `CMC_PT_T2 && timing.read_drive;
  endsequence
  sequence s_one_clk;
    sense_strobe ##1 !sense_strobe;
  endsequence

  a_strobe_one_clk: assert property (s_t2_pulse |=> s_one_clk)
    else $error("strobe is not one clock after T2");
  a_mdr_capture: assert property (
    s_t2_pulse |=> mdr == $past(sense_bit))
    else $error("sensed word not captured");
  a_inhibit_inverse: assert property (
    timing.inhibit |-> inhibit_drive == ~mdr)
    else $error("inhibit drive is not the inverted word");
  a_inhibit_quiet: assert property (
    !timing.inhibit |-> inhibit_drive == '0)
    else $error("inhibit drive outside inhibit timing");
  a_mdr_kept: assert property (timing.inhibit |-> $stable(mdr))
    else $error("data register moved while writing");
  a_read_dir: assert property (
    timing.read_drive |-> timing.read_dir && !timing.write_dir)
    else $error("read drive in the wrong direction");
  a_write_dir: assert property (
    timing.write_drive |-> timing.write_dir && !timing.read_dir)
    else $error("write drive not reversed");
  a_addr_held: assert property (
    timing.write_drive |-> $stable(address_reg))
    else $error("address moved during write drive");
  a_flag_read: assert property (
    timing.read_drive |-> cycle_active_flag)
    else $error("read drive without an active cycle");
  a_coord_map: assert property (
    $past(ce) && !$past(reset) |->
      coord.stack_sel == 4'h1 << $past(gated_address_line[13:12]) &&
      coord.y_true == 8'h01 << $past(gated_address_line[11:9]) &&
      coord.y_comp == 8'h01 << $past(gated_address_line[8:6]) &&
      coord.x_true == 8'h01 << $past(gated_address_line[5:3]) &&
      coord.x_comp == 8'h01 << $past(gated_address_line[2:0]))
    else $error("coordinate decode wrong");
endmodule : cmc_cycle_asserts

bind cmc_core_memory_cycle_control cmc_cycle_asserts u_asserts (
  .clk, .reset, .ce, .pulse_adv, .pulse_time, .sense_bit, .address_reg,
  .gated_address_line, .coord, .mdr, .inhibit_drive, .timing,
  .sense_strobe, .cycle_active_flag
);

// ==== verification/cmc_timing_chain.sv ====
// timing chain model: steps pulse times T24..T0, Tp of each word
`timescale 1ns/10ps
`include "cmc_map.svh"

module cmc_timing_chain (
  input  wire logic  clk,        // clock
  input  wire logic  reset,      // sync reset
  input  wire logic  run,        // low stalls the chain
  output logic       pulse_adv,  // new pulse time
  output logic [4:0] pulse_time  // pulse code
);
  logic [1:0] div;
  logic [1:0] next_div;
  logic [4:0] next_time;

  // word order
  // four clocks a pulse time keeps runs short, far from the cycle limit
  always_comb begin
    next_div  = run ? div + 2'h1 : div;
    next_time = pulse_time;
    if (run && div == 2'h3) begin
      next_time = (pulse_time == `CMC_PT_TP) ? `CMC_PT_T24 :
                  (pulse_time == 5'h00) ? `CMC_PT_TP : pulse_time - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div        <= 2'h0;
      pulse_adv  <= 1'b0;
      pulse_time <= `CMC_PT_T24;
    end else begin
      div        <= next_div;
      pulse_adv  <= run && div == 2'h3;
      pulse_time <= next_time;
    end
  end
endmodule : cmc_timing_chain

// ==== verification/cmc_core_memory_cycle_control_bench.sv ====
// self-checking bench for the core memory cycle control
`timescale 1ns/10ps
`include "cmc_map.svh"

module cmc_core_memory_cycle_control_bench;
  import cmc_pkg::*;
  logic clk, reset, ce, run, pulse_adv, mem_request, time_share, w_priority;
  logic write_request, overrun_clear, sense_strobe, cycle_active_flag;
  logic cycle_overrun;
  logic [4:0] pulse_time;
  logic [13:0] new_address, w_interlace_address_bit, y_interlace_address_bit;
  logic [13:0] address_reg, gated_address_line, last;
  logic [24:0] write_word, sense_bit, mdr, inhibit_drive;
  cmc_coord_type coord;
  cmc_timing_type timing;
  int n_fail, comparisons;

  cmc_timing_chain chain (.clk, .reset, .run, .pulse_adv, .pulse_time);
  cmc_core_memory_cycle_control dut (.clk, .reset, .ce, .pulse_adv,
    .pulse_time, .mem_request, .new_address, .time_share, .w_priority,
    .w_interlace_address_bit, .y_interlace_address_bit, .write_request,
    .write_word, .sense_bit, .overrun_clear, .address_reg,
    .gated_address_line, .coord, .mdr, .inhibit_drive, .timing,
    .sense_strobe, .cycle_active_flag, .cycle_overrun);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_pt(input logic [4:0] code);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(pulse_adv && pulse_time == code) && n < 300);
    if (n >= 300) begin
      n_fail++;
      $display("mismatch at %0t: pulse time never came", $time);
    end
    #1;
  endtask : wait_pt

  function automatic cmc_coord_type dec(input logic [13:0] v);
    dec.stack_sel = 4'h1 << v[13:12];
    dec.y_true = 8'h01 << v[11:9];
    dec.y_comp = 8'h01 << v[8:6];
    dec.x_true = 8'h01 << v[5:3];
    dec.x_comp = 8'h01 << v[2:0];
  endfunction : dec

  task automatic t_cycle(input logic [13:0] a, input logic [24:0] s,
                         input logic wr, input logic [24:0] ww);
    logic [24:0] e, inv;
    e = wr ? ww : s;
    inv = ~e;
    {mem_request, new_address, sense_bit} = {1'b1, a, s};
    {write_request, write_word} = {wr, ww};
    wait_pt(`CMC_PT_T10);
    check(address_reg, 14'h0000);
    wait_pt(`CMC_PT_T9);
    mem_request = 1'b0;
    last = a;
    check(address_reg, a);
    wait_pt(`CMC_PT_T8);
    check({cycle_active_flag, mdr}, {1'b1, 25'h0});
    wait_pt(`CMC_PT_T7);
    check(timing.read_drive && timing.read_dir, 1'b1);
    wait_pt(`CMC_PT_T2);
    check({sense_strobe, mdr}, {1'b1, s});
    sense_bit = ~s;
    wait_pt(`CMC_PT_T21);
    check(inhibit_drive, inv);
    wait_pt(`CMC_PT_T18);
    check(timing.write_drive && timing.write_dir, 1'b1);
    wait_pt(`CMC_PT_T12);
    check({timing.write_drive, address_reg}, {1'b0, a});
    wait_pt(`CMC_PT_T8);
    check(mdr, e);
    check({cycle_active_flag, timing.inhibit}, 2'b00);
    // the flipped sense word must not be strobed outside a read phase
    wait_pt(`CMC_PT_T2);
    check({sense_strobe, mdr}, {1'b0, e});
    $display("cycle test at %h done", a);
  endtask : t_cycle

  task automatic t_gate;
    logic [13:0] e;
    for (int m = 0; m < 3; m++) begin
      time_share = (m != 0);
      w_priority = (m == 1);
      e = (m == 0) ? last : (m == 1) ? w_interlace_address_bit :
          y_interlace_address_bit;
      repeat (3) @(posedge clk);
      #1;
      check(gated_address_line, e);
      check(coord, dec(e));
    end
    // clock enable low: a source change must not reach the lines
    ce = 1'b0;
    w_priority = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(gated_address_line, y_interlace_address_bit);
    check(coord, dec(y_interlace_address_bit));
    ce = 1'b1;
    time_share = 1'b0;
    $display("address gating test done");
  endtask : t_gate

  task automatic t_overrun;
    mem_request = 1'b1;
    wait_pt(`CMC_PT_T10);
    wait_pt(`CMC_PT_T9);
    mem_request = 1'b0;
    wait_pt(`CMC_PT_T7);
    run = 1'b0;
    repeat (1190) @(posedge clk);
    #1;
    check(cycle_overrun, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    check(cycle_overrun, 1'b1);
    run = 1'b1;
    wait_pt(`CMC_PT_T8);
    overrun_clear = 1'b1;
    @(posedge clk);
    #1;
    overrun_clear = 1'b0;
    check(cycle_overrun, 1'b0);
    $display("overrun test done");
  endtask : t_overrun

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    {reset, ce, run, mem_request, time_share, w_priority} = 6'b111000;
    {write_request, overrun_clear, new_address, last} = '0;
    {write_word, sense_bit} = '0;
    w_interlace_address_bit = 14'h2A5C;
    y_interlace_address_bit = 14'h15A3;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    t_cycle(14'h3037, 25'h1555555, 1'b0, 25'h0);
    t_cycle(14'h0070, 25'h0F0F0F0, 1'b1, 25'h1234567);
    t_cycle(14'h3FFF, 25'h1FFFFFF, 1'b0, 25'h0);
    t_cycle(14'h0000, 25'h0000000, 1'b1, 25'h1FFFFFF);
    t_gate;
    t_overrun;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule : cmc_core_memory_cycle_control_bench
